// File: sdlc_defines.vh
/*
 constants for the lane control block: register offsets, field positions,
 reset values and timing counts. assumes a 125 MHz aclk.
*/
`ifndef SDLC_DEFINES_VH
`define SDLC_DEFINES_VH
// register byte offsets
`define SDLC_OFF_PLL       8'h00
`define SDLC_OFF_STATUS    8'h04
`define SDLC_OFF_PORTMODE  8'h08
`define SDLC_OFF_RXCFG0    8'h10
`define SDLC_OFF_TXCFG0    8'h20
// lane config fields
`define SDLC_F_EN          0
`define SDLC_F_WIDTH_LO    1
`define SDLC_F_RATE_LO     4
`define SDLC_F_ALIGN_LO    10
`define SDLC_F_LOS_LO      12
`define SDLC_F_CDR_LO      15
`define SDLC_F_EQ_LO       18
`define SDLC_WIDTH20       3'h2
`define SDLC_ALIGN_COMMA   2'h1
`define SDLC_CDR_SECOND    3'h1
`define SDLC_EQ_OFF        4'h0
`define SDLC_EQ_FULL       4'h1
`define SDLC_RATE_HALF     2'h1
`define SDLC_RATE_QUARTER  2'h2
`define SDLC_RATE_EIGHTH   2'h3
// status fields
`define SDLC_ST_LOCK       0
`define SDLC_ST_LOS_LO     4
// reset values
`define SDLC_RST_CFG       32'h00000000
`define SDLC_RST_PORTMODE  3'h0
`define SDLC_PORTMODE_MAX  3'h4
// timing
`define SDLC_CLK_MHZ       125
`define SDLC_SETTLE_NS     1000000000
`define SDLC_SETTLE_CYC    ((`SDLC_SETTLE_NS / 1000) * `SDLC_CLK_MHZ)
`define SDLC_LOCK_CYC      200
`define SDLC_EQ_WIN        12'hfff
`define SDLC_EQ_THRESH     8'h10
`define SDLC_CDR_MAJ       4'h5
`endif

// File: sdlc_cdr.v
/*
 one lane of majority-vote clock recovery, first or second order.
 assumes sample words arrive on aclk with a one-cycle valid.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_defines.vh"
module sdlc_cdr (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       lane_en,
	input  wire       freeze,
	input  wire       second_order,
	input  wire       win_valid,
	input  wire [7:0] data_samp,
	input  wire [8:0] phase_samp,
	output reg        step_early_q,
	output reg        step_late_q,
	output reg  [5:0] phase_q
);
	reg        last_q;
	reg  [3:0] freq_q;
	reg  [3:0] n_early;
	reg  [3:0] n_late;
	reg  [8:0] dd;
	reg        maj_e;
	reg        maj_l;
	reg        go_e;
	reg        go_l;
	integer    i;
	//////////////////////////////////////////////////////////////////////
	// vote count over one window
	always @* begin
		n_early = 4'h0;
		n_late = 4'h0;
		dd = {data_samp, last_q};
		for (i = 0; i < 8; i = i + 1) begin
			if (dd[i] != dd[i+1]) begin
				if (phase_samp[i] == dd[i+1])
					n_early = n_early + 4'h1;
				else
					n_late = n_late + 4'h1;
			end
		end
		maj_e = (n_early >= `SDLC_CDR_MAJ);
		maj_l = (n_late >= `SDLC_CDR_MAJ);
		if (second_order) begin
			go_e = maj_e | (!maj_l && freq_q[3] == 1'b0 && freq_q != 4'h0);
			go_l = maj_l | (!maj_e && freq_q[3] == 1'b1);
		end else begin
			go_e = maj_e;
			go_l = maj_l;
		end
	end
	//////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		if (!aresetn || !lane_en) begin
			last_q <= 1'b0;
			freq_q <= 4'h0;
			phase_q <= 6'h00;
			step_early_q <= 1'b0;
			step_late_q <= 1'b0;
		end else begin
			step_early_q <= 1'b0;
			step_late_q <= 1'b0;
			if (win_valid && !freeze) begin
				last_q <= data_samp[7];
				if (go_e) begin
					step_early_q <= 1'b1;
					phase_q <= phase_q - 6'h01;
				end else if (go_l) begin
					step_late_q <= 1'b1;
					phase_q <= phase_q + 6'h01;
				end
				if (second_order && maj_e && freq_q != 4'h7)
					freq_q <= freq_q + 4'h1;
				else if (second_order && maj_l && freq_q != 4'h8)
					freq_q <= freq_q - 4'h1;
				else if (!second_order)
					freq_q <= 4'h0;
			end
		end
	end
endmodule // sdlc_cdr
`default_nettype wire

// File: sdlc_lane_ctrl.v
/*
 four-lane receive/transmit control with an axi4-lite register slave.
 assumes sample words, equalizer votes and comma hits come from aclk
 logic; loss-of-signal pins are asynchronous.
*/
// Local design decisions: the register offsets and the AXI4-Lite register port.
// How it works
// - receiver enable low gates rx logic, clocks
// - signal loss detect powered independently of receiver
// - signal loss freezes clock recovery updates
// - phase sample examined only on data transitions
// - window of eight data, nine phase samples
// - first order steps phase only on early/late majority
// - first order gives one step per majority
// - second order steps from net majority history
// - align field 01 selects comma alignment
// - core logic may request single-bit realignment jog
// - full adaptive mode moves zero at gain limits
// - gain decisions voted over a long interval
// - adaptation off gives flat max gain
// - partial mode adapts gain, zero fixed
// - tx enable low gates tx, byte clock runs
// - rate field 01 is half rate
// - rate codes 10 and 11 quarter and eighth rate
// - bus width field 010 selects 20-bit
// - 1x port uses one lane
// - 2x uses two lanes, 4x all four
// - only documented lane groupings are accepted
// - pll locks 200 cycles after settle, pollable
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_defines.vh"
module sdlc_lane_ctrl #(
	parameter SETTLE_CYC = `SDLC_SETTLE_CYC
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [3:0]  rx_los_pin,
	input  wire [3:0]  rx_win_valid,
	input  wire [31:0] rx_data_samp,
	input  wire [35:0] rx_phase_samp,
	input  wire [3:0]  rx_comma_seen,
	input  wire [3:0]  rx_align_jog,
	input  wire [3:0]  eq_vote_up,
	input  wire [3:0]  eq_vote_dn,
	output reg         pll_locked,
	output reg  [3:0]  rx_clk_gate_en,
	output reg  [3:0]  tx_clk_gate_en,
	output reg  [3:0]  tx_byte_clock_out_en,
	output reg  [3:0]  los_det_en,
	output reg  [3:0]  rx_realign,
	output reg  [3:0]  cdr_step_early,
	output reg  [3:0]  cdr_step_late,
	output reg  [15:0] eq_gain,
	output reg  [11:0] eq_zero,
	output reg  [3:0]  eq_flat,
	output reg  [3:0]  lane_width20,
	output reg  [7:0]  lane_samp_code,
	output reg  [7:0]  lane_port,
	output reg  [7:0]  lane_port_width
);
	reg  [31:0] rxcfg_q [0:3];
	reg  [31:0] txcfg_q [0:3];
	reg         pll_en_q;
	reg  [2:0]  portmode_q;
	reg  [26:0] pll_cnt_q;
	reg         settled_q;
	reg  [3:0]  los_m_q;
	reg  [3:0]  los_s_q;
	reg  [3:0]  los_flag_q;
	reg         aw_got_q;
	reg         w_got_q;
	reg  [7:0]  awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	wire [3:0]  step_e;
	wire [3:0]  step_l;
	reg         aw_n;
	reg         w_n;
	reg         do_wr;
	reg  [31:0] rd_d;
	reg         rd_err;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  st;
		integer b;
		begin
			for (b = 0; b < 4; b = b + 1)
				merge[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// axi4-lite write path
	always @* begin
		aw_n = aw_got_q | (s_axi_awvalid & s_axi_awready);
		w_n = w_got_q | (s_axi_wvalid & s_axi_wready);
		do_wr = aw_got_q & w_got_q & !s_axi_bvalid;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				awaddr_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				if (awaddr_q[7:6] != 2'h0 || awaddr_q[1:0] != 2'h0)
					s_axi_bresp <= 2'h2;
				else if (awaddr_q == `SDLC_OFF_STATUS)
					s_axi_bresp <= 2'h2;
				else if (awaddr_q == `SDLC_OFF_PORTMODE && wstrb_q[0]
						&& wdata_q[2:0] > `SDLC_PORTMODE_MAX)
					s_axi_bresp <= 2'h2;
				else if (awaddr_q[7:4] == 4'h0 && awaddr_q[3:2] == 2'h3)
					s_axi_bresp <= 2'h2;
			end else begin
				aw_got_q <= aw_n;
				w_got_q <= w_n;
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
			s_axi_awready <= !aw_n && !do_wr && !(s_axi_bvalid && !s_axi_bready);
			s_axi_wready <= !w_n && !do_wr && !(s_axi_bvalid && !s_axi_bready);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// register storage
	always @(posedge aclk) begin : regs
		integer n;
		if (!aresetn) begin
			for (n = 0; n < 4; n = n + 1) begin
				rxcfg_q[n] <= `SDLC_RST_CFG;
				txcfg_q[n] <= `SDLC_RST_CFG;
			end
			pll_en_q <= 1'b0;
			portmode_q <= `SDLC_RST_PORTMODE;
		end else if (do_wr) begin
			if (awaddr_q == `SDLC_OFF_PLL && wstrb_q[0])
				pll_en_q <= wdata_q[0];
			if (awaddr_q == `SDLC_OFF_PORTMODE && wstrb_q[0]
					&& wdata_q[2:0] <= `SDLC_PORTMODE_MAX)
				portmode_q <= wdata_q[2:0];
			if (awaddr_q[7:4] == 4'h1)
				rxcfg_q[awaddr_q[3:2]] <= merge(rxcfg_q[awaddr_q[3:2]], wdata_q, wstrb_q);
			if (awaddr_q[7:4] == 4'h2)
				txcfg_q[awaddr_q[3:2]] <= merge(txcfg_q[awaddr_q[3:2]], wdata_q, wstrb_q);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// axi4-lite read path
	always @* begin
		rd_d = 32'h00000000;
		rd_err = 1'b0;
		if (s_axi_araddr[7:4] == 4'h1 && s_axi_araddr[1:0] == 2'h0)
			rd_d = rxcfg_q[s_axi_araddr[3:2]];
		else if (s_axi_araddr[7:4] == 4'h2 && s_axi_araddr[1:0] == 2'h0)
			rd_d = txcfg_q[s_axi_araddr[3:2]];
		else if (s_axi_araddr == `SDLC_OFF_PLL)
			rd_d = {31'h00000000, pll_en_q};
		else if (s_axi_araddr == `SDLC_OFF_STATUS)
			rd_d = {24'h000000, los_flag_q, 3'h0, pll_locked};
		else if (s_axi_araddr == `SDLC_OFF_PORTMODE)
			rd_d = {29'h00000000, portmode_q};
		else
			rd_err = 1'b1;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_d;
				s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// pll settle and lock
	always @(posedge aclk) begin
		if (!aresetn || !pll_en_q) begin
			pll_cnt_q <= 27'h0000000;
			settled_q <= 1'b0;
			pll_locked <= 1'b0;
		end else if (!settled_q) begin
			if (pll_cnt_q >= SETTLE_CYC[26:0] - 27'h0000001) begin
				settled_q <= 1'b1;
				pll_cnt_q <= 27'h0000000;
			end else
				pll_cnt_q <= pll_cnt_q + 27'h0000001;
		end else if (!pll_locked) begin
			if (pll_cnt_q >= `SDLC_LOCK_CYC - 1)
				pll_locked <= 1'b1;
			else
				pll_cnt_q <= pll_cnt_q + 27'h0000001;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// loss of signal: pin sync, powered from its own field
	always @(posedge aclk) begin
		if (!aresetn) begin
			los_m_q <= 4'h0;
			los_s_q <= 4'h0;
		end else begin
			los_m_q <= rx_los_pin;
			los_s_q <= los_m_q;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// port grouping
	always @(posedge aclk) begin
		if (!aresetn) begin
			lane_port <= 8'h00;
			lane_port_width <= 8'h00;
		end else begin
			case (portmode_q)
			3'h0: begin
				lane_port <= 8'he4;
				lane_port_width <= 8'h00;
			end
			3'h1: begin
				lane_port <= 8'he0;
				lane_port_width <= 8'h05;
			end
			3'h2: begin
				lane_port <= 8'ha4;
				lane_port_width <= 8'h50;
			end
			3'h3: begin
				lane_port <= 8'ha0;
				lane_port_width <= 8'h55;
			end
			3'h4: begin
				lane_port <= 8'h00;
				lane_port_width <= 8'haa;
			end
			default: begin
				lane_port <= 8'he4;
				lane_port_width <= 8'h00;
			end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// per-lane control
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			wire       rx_en = rxcfg_q[g][`SDLC_F_EN];
			wire [3:0] eqm = rxcfg_q[g][`SDLC_F_EQ_LO +: 4];
			wire [1:0] rate = rxcfg_q[g][`SDLC_F_RATE_LO +: 2];
			wire [12:0] thr = {5'h00, `SDLC_EQ_THRESH};
			reg  [11:0] win_q;
			reg  [12:0] vote_q;
			reg         jog_q;

			sdlc_cdr u_cdr (
				.aclk         (aclk),
				.aresetn      (aresetn),
				.lane_en      (rx_en),
				.freeze       (los_flag_q[g]),
				.second_order (rxcfg_q[g][`SDLC_F_CDR_LO +: 3] == `SDLC_CDR_SECOND),
				.win_valid    (rx_win_valid[g]),
				.data_samp    (rx_data_samp[g*8 +: 8]),
				.phase_samp   (rx_phase_samp[g*9 +: 9]),
				.step_early_q (step_e[g]),
				.step_late_q  (step_l[g]),
				.phase_q      ()
			);

			always @(posedge aclk) begin
				if (!aresetn) begin
					los_flag_q[g] <= 1'b0;
					los_det_en[g] <= 1'b0;
					rx_clk_gate_en[g] <= 1'b0;
					tx_clk_gate_en[g] <= 1'b0;
					tx_byte_clock_out_en[g] <= 1'b0;
					rx_realign[g] <= 1'b0;
					cdr_step_early[g] <= 1'b0;
					cdr_step_late[g] <= 1'b0;
					lane_width20[g] <= 1'b0;
					lane_samp_code[g*2 +: 2] <= 2'h0;
					jog_q <= 1'b0;
				end else begin
					los_det_en[g] <= rxcfg_q[g][`SDLC_F_LOS_LO +: 3] != 3'h0;
					los_flag_q[g] <= (rxcfg_q[g][`SDLC_F_LOS_LO +: 3] != 3'h0)
						& los_s_q[g];
					rx_clk_gate_en[g] <= rx_en;
					tx_clk_gate_en[g] <= txcfg_q[g][`SDLC_F_EN];
					tx_byte_clock_out_en[g] <= pll_locked;
					cdr_step_early[g] <= step_e[g] & rx_en;
					cdr_step_late[g] <= step_l[g] & rx_en;
					jog_q <= rx_align_jog[g];
					if (rxcfg_q[g][`SDLC_F_ALIGN_LO +: 2] == `SDLC_ALIGN_COMMA)
						rx_realign[g] <= rx_en & rx_comma_seen[g];
					else
						rx_realign[g] <= rx_en & rx_align_jog[g] & !jog_q;
					lane_width20[g] <= rxcfg_q[g][`SDLC_F_WIDTH_LO +: 3] == `SDLC_WIDTH20;
					case (rate)
					`SDLC_RATE_HALF:    lane_samp_code[g*2 +: 2] <= 2'h2;
					`SDLC_RATE_QUARTER: lane_samp_code[g*2 +: 2] <= 2'h1;
					`SDLC_RATE_EIGHTH:  lane_samp_code[g*2 +: 2] <= 2'h0;
					default:            lane_samp_code[g*2 +: 2] <= 2'h3;
					endcase
				end
			end

			// equalizer adaptation, vote sum wide enough for a one-sided window
			always @(posedge aclk) begin
				if (!aresetn) begin
					win_q <= 12'h000;
					vote_q <= 13'h0000;
					eq_gain[g*4 +: 4] <= 4'hf;
					eq_zero[g*3 +: 3] <= 3'h0;
					eq_flat[g] <= 1'b1;
				end else if (!rx_en || eqm == `SDLC_EQ_OFF) begin
					win_q <= 12'h000;
					vote_q <= 13'h0000;
					eq_gain[g*4 +: 4] <= 4'hf;
					eq_flat[g] <= 1'b1;
				end else begin
					eq_flat[g] <= 1'b0;
					if (eqm[3])
						eq_zero[g*3 +: 3] <= eqm[2:0];
					win_q <= win_q + 12'h001;
					vote_q <= vote_q + {12'h000, eq_vote_up[g]} - {12'h000, eq_vote_dn[g]};
					if (win_q == `SDLC_EQ_WIN) begin
						win_q <= 12'h000;
						vote_q <= 13'h0000;
						if (!vote_q[12] && vote_q >= thr) begin
							if (eq_gain[g*4 +: 4] != 4'hf)
								eq_gain[g*4 +: 4] <= eq_gain[g*4 +: 4] + 4'h1;
							else if (eqm == `SDLC_EQ_FULL && eq_zero[g*3 +: 3] != 3'h7)
								eq_zero[g*3 +: 3] <= eq_zero[g*3 +: 3] + 3'h1;
						end else if (vote_q[12] && vote_q <= 13'h0000 - thr) begin
							if (eq_gain[g*4 +: 4] != 4'h0)
								eq_gain[g*4 +: 4] <= eq_gain[g*4 +: 4] - 4'h1;
							else if (eqm == `SDLC_EQ_FULL && eq_zero[g*3 +: 3] != 3'h0)
								eq_zero[g*3 +: 3] <= eq_zero[g*3 +: 3] - 3'h1;
						end
					end
				end
			end
		end
	endgenerate
endmodule // sdlc_lane_ctrl
`default_nettype wire

// File: sdlc_lane_chk.sv
/*
 port checker for sdlc_lane_ctrl, bound to every instance.
 assumes one aclk domain and synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module sdlc_lane_chk #(
	parameter SETTLE_CYC = 20
) (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [3:0]  rx_los_pin,
	input wire [3:0]  rx_win_valid,
	input wire [3:0]  rx_comma_seen,
	input wire [3:0]  rx_align_jog,
	input wire        pll_locked,
	input wire [3:0]  tx_byte_clock_out_en,
	input wire [3:0]  los_det_en,
	input wire [3:0]  rx_realign,
	input wire [3:0]  cdr_step_early,
	input wire [3:0]  cdr_step_late,
	input wire [15:0] eq_gain,
	input wire [3:0]  eq_flat,
	input wire [7:0]  lane_port_width
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reg [31:0] low_q;
	reg        jog0_q;
	wire step0 = cdr_step_early[0] | cdr_step_late[0];
	wire cause0 = rx_comma_seen[0] | (rx_align_jog[0] & !jog0_q);
	always @(posedge aclk)
		jog0_q <= rx_align_jog[0];
	always @(posedge aclk) begin
		if (!aresetn || pll_locked)
			low_q <= 32'h0;
		else if (low_q != 32'hffffffff)
			low_q <= low_q + 32'h1;
	end
	////////////////////////////////////////////////////////////////
	lock_wait_a: assert property ($rose(pll_locked) |-> low_q >= SETTLE_CYC + 200)
		else $error("lock too early");
	step_cause_a: assert property (step0 |-> $past(rx_win_valid[0], 2))
		else $error("step without window");
	step_excl_a: assert property ((cdr_step_early & cdr_step_late) == 4'h0)
		else $error("early and late together");
	los_freeze_a: assert property ($past(rx_los_pin[0], 4) && $past(los_det_en[0]) |-> !step0)
		else $error("step during signal loss");
	realign_cause_a: assert property (rx_realign[0] |-> $past(cause0))
		else $error("realign without cause");
	byte_clk_a: assert property (tx_byte_clock_out_en[0] |-> pll_locked || $past(pll_locked))
		else $error("byte clock without lock");
	eq_flat_a: assert property (eq_flat[0] |-> eq_gain[3:0] == 4'hf)
		else $error("flat not at max gain");
	port_group_a: assert property (lane_port_width inside {8'h00, 8'h05, 8'h50, 8'h55, 8'haa})
		else $error("illegal lane grouping");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data not held");
	lock_c: cover property ($rose(pll_locked));
	early_c: cover property (cdr_step_early[0]);
	late_c: cover property (cdr_step_late[0]);
	realign_c: cover property (rx_realign[0]);
endmodule // sdlc_lane_chk
bind sdlc_lane_ctrl sdlc_lane_chk #(.SETTLE_CYC(SETTLE_CYC)) i_sdlc_lane_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.rx_los_pin(rx_los_pin), .rx_win_valid(rx_win_valid), .rx_comma_seen(rx_comma_seen),
	.rx_align_jog(rx_align_jog), .pll_locked(pll_locked), .rx_realign(rx_realign),
	.tx_byte_clock_out_en(tx_byte_clock_out_en), .cdr_step_early(cdr_step_early),
	.los_det_en(los_det_en),
	.cdr_step_late(cdr_step_late), .eq_gain(eq_gain), .eq_flat(eq_flat),
	.lane_port_width(lane_port_width));
`default_nettype wire

// File: sdlc_link_peer.sv
/*
 remote link partner: sample windows and comma hits for lane 0.
 assumes tasks are called just after a rising aclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sdlc_link_peer (
	input  wire        aclk,
	output logic [3:0]  win_valid,
	output logic [31:0] data_samp,
	output logic [35:0] phase_samp,
	output logic [3:0]  comma_seen
);
	initial begin
		win_valid = 4'h0;
		data_samp = 32'h0;
		phase_samp = 36'h0;
		comma_seen = 4'h0;
	end
	// eight data and nine phase samples per window, one-cycle valid
	task send(input [7:0] d, input [8:0] p);
		win_valid <= 4'h1;
		data_samp <= {~{3{d}}, d};
		phase_samp <= {~{3{p}}, p};
		@(posedge aclk);
		win_valid <= 4'h0;
		data_samp <= ~data_samp;
		phase_samp <= ~phase_samp;
	endtask
	task comma();
		comma_seen <= 4'h1;
		@(posedge aclk);
		comma_seen <= 4'h0;
	endtask
endmodule // sdlc_link_peer
`default_nettype wire

// File: tb.sv
/*
 self-checking bench for sdlc_lane_ctrl over axi4-lite.
 assumes the bound checker and sdlc_link_peer on the sample inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_defines.vh"
module tb;
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0]  signal_loss_ctrl = 0, jog = 0, vup = 0, vdn = 0;
	wire awready, wready, bvalid, arready, rvalid, pll_locked;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata, dsamp;
	wire [35:0] psamp;
	wire [3:0] wv, cs, rxg, txg, bclk, losd, realign, se, sl, flat, w20;
	wire [15:0] gain;
	wire [11:0] zero;
	wire [7:0] scode, lport, lpw;
	int n_fail = 0, comparisons = 0, n;
	logic pv = 0;
	logic [1:0] r, s;
	logic [31:0] d, seed;
	logic [15:0] pwt [5] = '{16'he400, 16'he005, 16'ha450, 16'ha055, 16'h00aa};
	always #4 aclk = ~aclk;
	sdlc_link_peer i_sdlc_link_peer (.aclk(aclk), .win_valid(wv), .data_samp(dsamp),
		.phase_samp(psamp), .comma_seen(cs));
	sdlc_lane_ctrl #(.SETTLE_CYC(20)) i_sdlc_lane_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_los_pin(signal_loss_ctrl), .rx_win_valid(wv), .rx_data_samp(dsamp), .rx_phase_samp(psamp),
		.rx_comma_seen(cs), .rx_align_jog(jog), .eq_vote_up(vup), .eq_vote_dn(vdn),
		.pll_locked(pll_locked), .rx_clk_gate_en(rxg), .tx_clk_gate_en(txg),
		.tx_byte_clock_out_en(bclk), .los_det_en(losd), .rx_realign(realign),
		.cdr_step_early(se), .cdr_step_late(sl), .eq_gain(gain), .eq_zero(zero),
		.eq_flat(flat), .lane_width20(w20), .lane_samp_code(scode), .lane_port(lport),
		.lane_port_width(lpw));
	////////////////////////////////////////////////////////////////
	task chk(input [31:0] got, input [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] v, output [1:0] rs);
		logic ad, wd;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				ad = 1;
				awvalid <= 0;
			end
			if (wvalid && wready) begin
				wd = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		rs = bresp;
		bready <= 0;
		repeat (2) @(posedge aclk);
	endtask
	task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		v = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	function [31:0] rxc(input [1:0] rate, input [1:0] al, input [3:0] eq);
		return {10'h0, eq, 3'h0, 3'h1, al, 4'h0, rate, 3'h2, 1'b1};
	endfunction
	function [1:0] cdr_exp(input b0, input [7:0] dd, input [8:0] p);
		int e, l;
		logic b;
		e = 0;
		l = 0;
		for (int i = 0; i < 8; i++) begin
			b = (i == 0) ? b0 : dd[i - 1];
			if (b != dd[i]) begin
				if (p[i] == dd[i]) e++;
				else l++;
			end
		end
		return {e >= 5, l >= 5};
	endfunction
	task win(input [7:0] dd, input [8:0] p, input [1:0] ex);
		s = 0;
		i_sdlc_link_peer.send(dd, p);
		repeat (6) begin
			@(posedge aclk);
			s = s | {se[0], sl[0]};
		end
		chk(s, ex);
		pv = dd[7];
	endtask
	task watch(input [3:0] v);
		s = 0;
		repeat (4) begin
			@(posedge aclk);
			s[0] = s[0] | realign[0];
		end
		chk(s, 1);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#(8 * 40000);
		n_fail++;
		final_report;
	end
	initial begin
		seed = $urandom(32'h6e83);
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		chk(gain, 16'hffff);
		chk(flat, 4'hf);
		wr(`SDLC_OFF_PLL, 1, r);
		n = 0;
		while (!pll_locked && n < 400) begin
			@(posedge aclk);
			n++;
		end
		chk(n inside {[205:222]}, 1);
		rd(`SDLC_OFF_STATUS, d, r);
		chk(d[0], 1);
		chk({txg, bclk}, 8'h0f);
		wr(`SDLC_OFF_TXCFG0, 1, r);
		chk(txg, 4'h1);
		for (int k = 0; k < 4; k++) begin
			wr(`SDLC_OFF_RXCFG0, rxc(k, 1, 0), r);
			chk(scode[1:0], 3 - k);
		end
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 0), r);
		rd(`SDLC_OFF_RXCFG0, d, r);
		chk(d, rxc(1, 1, 0));
		chk({w20[0], rxg[0]}, 2'b11);
		wr(`SDLC_OFF_RXCFG0 + 8'h4, 32'h1000, r);
		chk({rxg[1], losd[1]}, 2'b01);
		rd(8'h40, d, r);
		chk(r, 2);
		chk(d, 0);
		wr(`SDLC_OFF_STATUS, 1, r);
		chk(r, 2);
		for (int k = 0; k < 6; k++) begin
			wr(`SDLC_OFF_PORTMODE, k, r);
			chk({r, lport, lpw}, {(k == 5) ? 2'b10 : 2'b00, pwt[(k < 5) ? k : 4]});
		end
		win(8'h55, 9'h055, 2'b10);
		win(8'h55, 9'h0aa, 2'b01);
		win(8'h00, 9'h0ff, 2'b00);
		win(8'h55, 9'h05a, 2'b00);
		win(8'h55, 9'h052, 2'b10);
		signal_loss_ctrl <= 4'h1;
		repeat (6) @(posedge aclk);
		win(8'h55, 9'h055, 2'b00);
		signal_loss_ctrl <= 4'h0;
		repeat (6) @(posedge aclk);
		for (int k = 0; k < 30; k++) begin
			d = $urandom;
			seed = $urandom;
			win(d[7:0], seed[8:0], cdr_exp(pv, d[7:0], seed[8:0]));
		end
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 0) | 32'h8000, r);
		win(8'h55, 9'h055, 2'b10);
		win(8'h55, 9'h05a, 2'b10);
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 0), r);
		i_sdlc_link_peer.comma();
		watch(1);
		wr(`SDLC_OFF_RXCFG0, rxc(1, 0, 0), r);
		jog <= 4'h1;
		watch(1);
		jog <= 4'h0;
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 4'hd), r);
		chk({zero[2:0], flat[0]}, 4'ha);
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 0), r);
		vup <= 4'h1;
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 1), r);
		repeat (4100) @(posedge aclk);
		chk({zero[2:0], gain[3:0]}, 7'h6f);
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 0), r);
		vup <= 4'h0;
		vdn <= 4'h1;
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 1), r);
		repeat (4100) @(posedge aclk);
		chk({zero[2:0], gain[3:0]}, 7'h6e);
		vdn <= 4'h0;
		wr(`SDLC_OFF_RXCFG0, rxc(1, 1, 0), r);
		chk({flat[0], gain[3:0]}, 5'h1f);
		final_report;
	end
endmodule // tb
`default_nettype wire
